// ===== hdl/kfh_handler.sv
// Keyboard function handler: key events in, host byte stream and mode controls out.
// Assumes key events and status inputs are synchronous to core_clk.
//
// Summary of operation
// R1: Configuration key enters configuration mode.
// R2: Arrow keys send cursor control sequences outside configuration and locator modes.
// R3: Break sends a break; with shift a long break.
// R4: Unshifted function keys each send their own control sequence.
// R5: Shift+print key freezes screen during copy; second press aborts.
// R6: Shift+pointer key enters locator mode and shows the cross cursor.
// R7: Shift+text key selects text mode, or resets text features if already there.
// R8: Shift+restart outside configuration does a soft reset keeping settings.
// R9: Delete sends DEL, line feed sends LF.
// R10: Return sends CR or CR LF per the new-line setting.
// R11: Hold key toggles host flow stop and lamp when pausing is enabled.
// R12: Control with a key sends the control code; escape sends ESC.
// R13: In configuration, space or up increments value, wrapping to zero.
// R14: In configuration, down decrements value, wrapping to the highest.
// R15: In configuration, return or right selects next parameter, wrapping.
// R16: In configuration, left selects previous parameter, wrapping.
// R17: Two letters select a parameter by code; unknown code rings bell.
// R18: A digit sets the value; invalid value rings bell.
// R19: In configuration shift+restart is full reset; unshifted rings bell.
// R20: Locator arrows move one dot, or ten with shift.
// R21: Other keys end locator, send key then position (or CR then key).
// R22: Enter or return ends locator and reports the position.
// R23: Delete ends locator without report; sends CR if host started it.
// R24: Keys typed during hold are buffered and sent after it ends.
// R25: Keyboard gives one event per press with shift and control states.
`timescale 1ns/1ns
`default_nettype none
module kfh_handler import kfh_pkg::*; #(
  parameter int FREEZE_CYCLES = FREEZE_CYC,
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Keyboard events
  input wire logic key_valid,
  input wire kfh_key_t key_in,
  output logic key_ready,
  // Host line
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output logic break_pulse,
  output logic long_break_pulse,
  output logic host_flow_stop,
  // Configuration and system status
  input wire logic flow_pause_enable,
  input wire logic newline_mode_param,
  input wire logic printer_present,
  input wire logic printer_done,
  input wire logic loc_host_start,
  input wire logic gfx_mode_req,
  // Mode and display controls
  output logic setup_active,
  output logic pointer_active,
  output logic [LOC_W-1:0] loc_x,
  output logic [LOC_W-1:0] loc_y,
  output logic text_mode,
  output logic graphics_mode,
  output logic gfx_settings_cancel,
  output logic text_features_reset,
  output logic soft_reset,
  output logic power_reset,
  output logic screen_freeze,
  output logic print_start,
  output logic print_abort,
  output logic hold_lamp,
  output logic bell,
  output logic [PW-1:0] param_idx,
  output logic [VW-1:0] param_val
);
  // ---------------------------------------------------------------
  // Key decode
  // ---------------------------------------------------------------
  kfh_mode_t mode_r;
  logic [7:0] kc;
  logic ksh, kct;
  assign kc = key_in.code;
  assign ksh = key_in.shift;
  assign kct = key_in.ctrl;
  wire tk = key_valid & key_ready; // [R25]
  wire m_norm = (mode_r == M_NORM);
  wire m_setup = (mode_r == M_SETUP);
  wire m_loc = (mode_r == M_LOC);
  wire is_arrow = (kc[7:2] == 6'b100000);
  wire is_pf = (kc[7:2] == 6'b100001);
  wire [1:0] kn = kc[1:0];
  wire is_brk = (kc == K_BREAK);
  wire is_setk = (kc == K_SETUP);
  wire is_hold = (kc == K_HOLD);
  wire is_cr = (kc == C_CR) | (kc == K_ENTER);
  wire is_del = (kc == C_DEL);
  wire is_up = (kc == K_UP) | (kc == C_SP);
  wire is_letter = (kc[7:5] == 3'b010) & (kc[4:0] != 5'h00) & (kc[4:0] <= 5'h1A);
  wire is_digit = (kc[7:4] == 4'h3) & (kc[3:0] <= 4'h9);
  wire sh_pf1 = is_pf & ksh & (kn == 2'd0);
  wire sh_pf2 = is_pf & ksh & (kn == 2'd1);
  wire sh_pf3 = is_pf & ksh & (kn == 2'd2);
  wire pf4 = is_pf & (kn == 2'd3);
  wire [7:0] kbyte = (kct & kc[6]) ? {3'b000, kc[4:0]} : kc; // [R12]
  wire loc_other = ~is_arrow & ~sh_pf2 & ~is_cr & ~is_del & ~is_setk & ~is_brk;

  // ---------------------------------------------------------------
  // Output sequence builder
  // ---------------------------------------------------------------
  logic [7:0] sb [SEQ_MAX];
  logic [2:0] slen;
  logic [7:0] pos [4];
  logic loc_host_r;
  logic [LOC_W-1:0] lx_r, ly_r;
  assign pos[0] = {3'b001, lx_r[9:5]};
  assign pos[1] = {3'b001, lx_r[4:0]};
  assign pos[2] = {3'b001, ly_r[9:5]};
  assign pos[3] = {3'b001, ly_r[4:0]};

  always_comb begin
    for (int i = 0; i < SEQ_MAX; i++) begin
      sb[i] = 8'h00;
    end
    slen = 3'd0;
    if (m_loc) begin
      if (is_cr) begin
        for (int i = 0; i < 4; i++) sb[i] = pos[i]; // [R22]
        slen = 3'd4;
      end else if (is_del) begin
        sb[0] = C_CR; // [R23]
        slen = loc_host_r ? 3'd1 : 3'd0;
      end else if (loc_other) begin
        if (loc_host_r) begin
          sb[0] = C_CR; // [R21]
          sb[1] = kbyte;
          slen = 3'd2;
        end else begin
          sb[0] = kbyte; // [R21]
          for (int i = 0; i < 4; i++) sb[i+1] = pos[i];
          slen = 3'd5;
        end
      end
    end else if (m_norm) begin
      if (is_arrow) begin
        sb[0] = C_ESC; // [R2]
        sb[1] = C_CSI;
        sb[2] = ARROW_BASE + {6'd0, kn};
        slen = 3'd3;
      end else if (is_pf & ~ksh) begin
        sb[0] = C_ESC; // [R4]
        sb[1] = C_SS3;
        sb[2] = PF_BASE + {6'd0, kn};
        slen = 3'd3;
      end else if (is_cr) begin
        sb[0] = C_CR; // [R10]
        sb[1] = C_LF;
        slen = newline_mode_param ? 3'd2 : 3'd1;
      end else if (~kc[7]) begin
        sb[0] = kbyte; // [R9] [R12]
        slen = 3'd1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Sequencer into the transmit FIFO
  // ---------------------------------------------------------------
  // Keys are refused while a sequence drains, so a full FIFO stalls the keyboard
  logic [7:0] sq_r [SEQ_MAX];
  logic [2:0] sq_len_r, sq_idx_r;
  logic f_in_ready, hold_r;
  wire busy = (sq_idx_r != sq_len_r);
  assign key_ready = ~busy;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sq_len_r <= 3'd0;
      sq_idx_r <= 3'd0;
    end else if (tk) begin
      sq_r <= sb;
      sq_len_r <= slen;
      sq_idx_r <= 3'd0;
    end else if (busy & f_in_ready) begin
      sq_idx_r <= sq_idx_r + 3'd1;
    end
  end

  kfh_fifo #(.W(8), .D(DEPTH)) u_txq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .in_valid(busy),
    .in_data(sq_r[sq_idx_r]),
    .in_ready(f_in_ready),
    .out_valid(tx_valid),
    .out_data(tx_data),
    .out_ready(tx_ready & ~hold_r) // [R24]
  );

  // ---------------------------------------------------------------
  // Mode, locator and hold
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_r <= M_NORM;
      loc_host_r <= 1'b0;
    end else if (tk & is_setk) begin
      mode_r <= m_setup ? M_NORM : M_SETUP; // [R1]
    end else if (tk & ~m_setup & sh_pf2) begin
      mode_r <= M_LOC; // [R6]
      loc_host_r <= 1'b0;
    end else if (tk & m_loc & (is_cr | is_del | loc_other)) begin
      mode_r <= M_NORM; // [R21] [R22] [R23]
    end else if (loc_host_start & m_norm) begin
      mode_r <= M_LOC;
      loc_host_r <= 1'b1;
    end
  end

  wire [LOC_W-1:0] step = ksh ? LOC_COARSE : LOC_FINE;
  wire loc_mv = tk & m_loc & is_arrow;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      lx_r <= LOC_RST;
      ly_r <= LOC_RST;
    end else if (loc_mv) begin
      case (kn) // [R20]
        2'd0: ly_r <= ly_r - step;
        2'd1: ly_r <= ly_r + step;
        2'd2: lx_r <= lx_r + step;
        2'd3: lx_r <= lx_r - step;
        default: lx_r <= lx_r;
      endcase
    end
  end

  // Dropping the pause enable releases a hold so queued keys cannot stick
  always_ff @(posedge core_clk) begin
    if (sys_rst | ~flow_pause_enable) begin
      hold_r <= 1'b0;
    end else if (tk & is_hold & ~m_setup) begin
      hold_r <= ~hold_r; // [R11]
    end
  end

  // ---------------------------------------------------------------
  // Print freeze
  // ---------------------------------------------------------------
  logic print_r;
  logic [23:0] frz_r;
  wire prt_key = tk & ~m_setup & sh_pf1;
  wire prt_end = printer_present ? printer_done : (frz_r == 24'd1);
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      print_r <= 1'b0;
      frz_r <= 24'd0;
    end else if (prt_key) begin
      print_r <= ~print_r; // [R5]
      frz_r <= 24'(FREEZE_CYCLES);
    end else if (print_r) begin
      print_r <= ~prt_end; // [R5]
      frz_r <= frz_r - 24'd1;
    end
  end

  // ---------------------------------------------------------------
  // Configuration parameters
  // ---------------------------------------------------------------
  logic [VW-1:0] pv_r [NPARAM];
  logic [PW-1:0] pi_r;
  logic first_ok_r;
  logic [7:0] first_r;
  logic code_hit;
  logic [PW-1:0] code_idx;
  always_comb begin
    code_hit = 1'b0;
    code_idx = '0;
    for (int i = 0; i < NPARAM; i++) begin
      if (PCODE[i] == {first_r, kc}) begin
        code_hit = 1'b1;
        code_idx = PW'(i);
      end
    end
  end
  wire st = tk & m_setup;
  wire [VW-1:0] cur = pv_r[pi_r];
  wire [VW-1:0] vmax = PMAX[pi_r];
  wire dig_ok = (kc[3:0] <= vmax);
  wire full_rst = st & pf4 & ksh;
  wire code_done = st & is_letter & first_ok_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst | full_rst) begin
      pi_r <= '0;
      first_ok_r <= 1'b0;
      first_r <= 8'h00;
    end else if (st) begin
      first_ok_r <= is_letter & ~first_ok_r;
      first_r <= kc;
      if (kc == C_CR | kc == K_RIGHT) begin
        pi_r <= (pi_r == PW'(NPARAM-1)) ? '0 : pi_r + 1'b1; // [R15]
      end else if (kc == K_LEFT) begin
        pi_r <= (pi_r == '0) ? PW'(NPARAM-1) : pi_r - 1'b1; // [R16]
      end else if (code_done & code_hit) begin
        pi_r <= code_idx; // [R17]
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst | full_rst) begin
      for (int i = 0; i < NPARAM; i++) pv_r[i] <= PV_RST; // [R19]
    end else if (st & is_up) begin
      pv_r[pi_r] <= (cur == vmax) ? '0 : cur + 1'b1; // [R13]
    end else if (st & (kc == K_DOWN)) begin
      pv_r[pi_r] <= (cur == '0) ? vmax : cur - 1'b1; // [R14]
    end else if (st & is_digit & dig_ok) begin
      pv_r[pi_r] <= kc[VW-1:0]; // [R18]
    end
  end

  // ---------------------------------------------------------------
  // Text mode and one-cycle controls
  // ---------------------------------------------------------------
  logic text_r;
  wire txt_key = tk & ~m_setup & sh_pf3;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      text_r <= 1'b1;
    end else if (txt_key) begin
      text_r <= 1'b1; // [R7]
    end else if (gfx_mode_req) begin
      text_r <= 1'b0;
    end
  end

  wire bell_nxt = (tk & is_setk & ~m_setup) | (st & pf4 & ~ksh) // [R19]
                | (code_done & ~code_hit) | (st & is_digit & ~dig_ok); // [R17] [R18]
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {break_pulse, long_break_pulse, bell, soft_reset, power_reset} <= 5'h00;
      {gfx_settings_cancel, text_features_reset, print_start, print_abort} <= 4'h0;
    end else begin
      break_pulse <= tk & is_brk & ~ksh; // [R3]
      long_break_pulse <= tk & is_brk & ksh; // [R3]
      bell <= bell_nxt;
      soft_reset <= tk & ~m_setup & pf4 & ksh; // [R8]
      power_reset <= full_rst; // [R19]
      gfx_settings_cancel <= txt_key & ~text_r; // [R7]
      text_features_reset <= txt_key & text_r; // [R7]
      print_start <= prt_key & ~print_r; // [R5]
      print_abort <= prt_key & print_r; // [R5]
    end
  end

  assign setup_active = m_setup;
  assign pointer_active = m_loc;
  assign loc_x = lx_r;
  assign loc_y = ly_r;
  assign text_mode = text_r;
  assign graphics_mode = ~text_r;
  assign screen_freeze = print_r;
  assign hold_lamp = hold_r;
  assign host_flow_stop = hold_r;
  assign param_idx = pi_r;
  assign param_val = cur;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence setup_press_s;
    tk & m_norm & is_setk;
  endsequence
  sequence print_press_s;
    tk & m_norm & sh_pf1 & ~print_r;
  endsequence

  setup_entry_a: assert property (setup_press_s |=> setup_active && bell) // [R1]
    else $error("setup key did not enter configuration");
  arrow_seq_a: assert property (tk & m_norm & is_arrow |=> sq_len_r == 3'd3
      && sq_r[0] == C_ESC && sq_r[2] == ARROW_BASE + {6'd0, $past(kn)}) // [R2]
    else $error("arrow sequence wrong");
  long_break_a: assert property (tk & is_brk & ksh |=> long_break_pulse && !break_pulse) // [R3]
    else $error("shifted break not long");
  freeze_hold_a: assert property (print_press_s |=> print_start ##0 screen_freeze [*2]) // [R5]
    else $error("print freeze not held");
  text_reset_a: assert property (txt_key & text_r |=> text_features_reset
      && !gfx_settings_cancel && text_mode) // [R7]
    else $error("text features not reset");
  newline_a: assert property (tk & m_norm & (kc == C_CR)
      |=> sq_len_r == (newline_mode_param ? 3'd2 : 3'd1)) // [R10]
    else $error("return sequence length wrong");
  hold_toggle_a: assert property (tk & m_norm & is_hold & flow_pause_enable
      |=> hold_lamp != $past(hold_lamp)) // [R11]
    else $error("hold key did not toggle");
  up_wrap_a: assert property (st & is_up & (cur == vmax) |=> param_val == '0) // [R13]
    else $error("increment did not wrap");
  down_wrap_a: assert property (st & (kc == K_DOWN) & (cur == '0)
      |=> param_val == $past(vmax)) // [R14]
    else $error("decrement did not wrap");
  next_wrap_a: assert property (st & (kc == K_RIGHT) & (pi_r == PW'(NPARAM-1))
      |=> param_idx == '0) // [R15]
    else $error("next parameter did not wrap");
  loc_step_a: assert property (loc_mv & ksh & (kn == 2'd2)
      |=> loc_x == $past(lx_r) + LOC_COARSE) // [R20]
    else $error("coarse locator step wrong");
  hold_stall_a: assert property (hold_r && tx_valid |=> tx_valid && $stable(tx_data)) // [R24]
    else $error("data left during hold");
endmodule
`default_nettype wire

// ===== pkg/kfh_pkg.sv
// Constants, key codes and carrier types for the terminal key function handler.
// Assumes the keyboard scanner delivers one event per press with modifier states.
package kfh_pkg;
  // ---------------------------------------------------------------
  // Key identities above the ASCII range
  // ---------------------------------------------------------------
  localparam logic [7:0] K_UP = 8'h80;
  localparam logic [7:0] K_DOWN = 8'h81;
  localparam logic [7:0] K_RIGHT = 8'h82;
  localparam logic [7:0] K_LEFT = 8'h83;
  localparam logic [7:0] K_PF1 = 8'h84;
  localparam logic [7:0] K_BREAK = 8'h88;
  localparam logic [7:0] K_SETUP = 8'h89;
  localparam logic [7:0] K_HOLD = 8'h8A;
  localparam logic [7:0] K_ENTER = 8'h8B;
  // ---------------------------------------------------------------
  // Codes sent to the host
  // ---------------------------------------------------------------
  localparam logic [7:0] C_LF = 8'h0A;
  localparam logic [7:0] C_CR = 8'h0D;
  localparam logic [7:0] C_ESC = 8'h1B;
  localparam logic [7:0] C_SP = 8'h20;
  localparam logic [7:0] C_DEL = 8'h7F;
  localparam logic [7:0] C_CSI = 8'h5B;
  localparam logic [7:0] C_SS3 = 8'h4F;
  localparam logic [7:0] ARROW_BASE = 8'h41;
  localparam logic [7:0] PF_BASE = 8'h50;
  // ---------------------------------------------------------------
  // Configuration parameters
  // ---------------------------------------------------------------
  localparam int NPARAM = 8;
  localparam int PW = 3;
  localparam int VW = 4;
  localparam logic [VW-1:0] PV_RST = 4'h0;
  localparam logic [15:0] PCODE [NPARAM] = '{16'h5453, 16'h5253, 16'h5045, 16'h554B,
                                             16'h4349, 16'h5046, 16'h4E4C, 16'h584F};
  localparam logic [VW-1:0] PMAX [NPARAM] = '{4'h7, 4'h7, 4'h2, 4'h3,
                                             4'h1, 4'h1, 4'h1, 4'h1};
  // ---------------------------------------------------------------
  // Locator and timing
  // ---------------------------------------------------------------
  localparam int LOC_W = 10;
  localparam logic [LOC_W-1:0] LOC_FINE = 10'h001;
  localparam logic [LOC_W-1:0] LOC_COARSE = 10'h00A;
  localparam logic [LOC_W-1:0] LOC_RST = 10'h000;
  localparam int CLK_NS = 40;
  localparam int FREEZE_MS = 500;
  localparam int FREEZE_CYC = FREEZE_MS * 1000000 / CLK_NS;
  localparam int SEQ_MAX = 5;
  localparam int FIFO_DEPTH = 8;
  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [7:0] code;
    logic shift;
    logic ctrl;
  } kfh_key_t;
  typedef enum logic [1:0] {
    M_NORM = 2'b00,
    M_SETUP = 2'b01,
    M_LOC = 2'b11
  } kfh_mode_t;
endpackage

// ===== hdl/kfh_fifo.sv
// Synchronous FIFO of flip-flops with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module kfh_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rp_r];

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(D-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(D-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ===== dv/kfh_host_model.sv
// Host-side partner model: sinks the handler's transmit byte stream.
// Assumes one clock; stall holds ready low, slow accepts every other cycle.
`timescale 1ns/1ns
`default_nettype none
module kfh_host_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // Byte stream from the handler
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  input wire logic hold_lamp,
  // Pacing
  input wire logic stall,
  input wire logic slow
);
  logic [7:0] got[$];
  always @(posedge core_clk) begin
    // Nothing leaves while the line is held, whatever ready says
    if (!sys_rst && tx_valid && tx_ready && !hold_lamp) begin
      got.push_back(tx_data);
    end
    tx_ready <= !sys_rst && !stall && !(slow && tx_ready);
  end
endmodule
`default_nettype wire

// ===== dv/tb_kfh_handler.sv
// Self-checking bench for the key function handler.
// Assumes the host model sits on the transmit port; freeze shortened to 20 cycles.
`timescale 1ns/1ns
`default_nettype none
module tb_kfh_handler;
  import kfh_pkg::*;
  localparam int FRZ = 20;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic key_valid, key_ready, tx_valid, tx_ready, break_pulse, long_break_pulse;
  logic host_flow_stop, flow_pause_enable, newline_mode_param, printer_present;
  logic printer_done, loc_host_start, gfx_mode_req, setup_active, pointer_active;
  logic text_mode, graphics_mode, gfx_settings_cancel, text_features_reset, soft_reset;
  logic power_reset, screen_freeze, print_start, print_abort, hold_lamp, bell, stall, slow;
  logic [7:0] tx_data;
  logic [8:0] pl;
  logic [LOC_W-1:0] loc_x, loc_y;
  logic [PW-1:0] param_idx;
  logic [VW-1:0] param_val;
  kfh_key_t key_in;
  int failures = 0;
  int num_checks = 0;
  always #20 core_clk = ~core_clk;
  kfh_handler #(.FREEZE_CYCLES(FRZ), .DEPTH(8)) i_kfh_handler (.core_clk, .sys_rst,
    .key_valid, .key_in, .key_ready, .tx_valid, .tx_data, .tx_ready, .break_pulse,
    .long_break_pulse, .host_flow_stop, .flow_pause_enable, .newline_mode_param,
    .printer_present, .printer_done, .loc_host_start, .gfx_mode_req, .setup_active,
    .pointer_active, .loc_x, .loc_y, .text_mode, .graphics_mode, .gfx_settings_cancel,
    .text_features_reset, .soft_reset, .power_reset, .screen_freeze, .print_start,
    .print_abort, .hold_lamp, .bell, .param_idx, .param_val);
  kfh_host_model i_kfh_host_model (.core_clk, .sys_rst, .tx_valid, .tx_data, .tx_ready,
    .hold_lamp, .stall, .slow);
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // One press per call; pulses are captured just after the take edge
  task automatic key(input logic [7:0] c, input logic s = 1'b0, input logic t = 1'b0);
    int n;
    n = 0;
    key_in = '{code: c, shift: s, ctrl: t};
    key_valid = 1'b1;
    while (key_ready !== 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    cyc(1);
    key_valid = 1'b0;
    pl = {print_start, break_pulse, long_break_pulse, bell, soft_reset, power_reset,
          print_abort, gfx_settings_cancel, text_features_reset};
    cyc(1);
  endtask
  task automatic exp_tx(input int n, input logic [71:0] v);
    int k;
    k = 0;
    while (i_kfh_host_model.got.size() < n && k < 300) begin
      cyc(1);
      k++;
    end
    for (int i = 0; i < n; i++) begin
      chk("tx byte", i_kfh_host_model.got[i], v[8*(n-1-i) +: 8]);
    end
    cyc(6);
    chk("tx count", i_kfh_host_model.got.size(), n);
    i_kfh_host_model.got.delete();
  endtask
  task automatic rst();
    sys_rst = 1'b1;
    cyc(2);
    sys_rst = 1'b0;
  endtask
  task automatic pulse_in(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    key_valid = 1'b0;
    key_in = '0;
    {flow_pause_enable, newline_mode_param, printer_present, printer_done} = 4'h0;
    {loc_host_start, gfx_mode_req, stall, slow} = 4'h0;
    cyc(2);
    sys_rst = 1'b0;
    slow = 1'b1;
    for (int n = 0; n < 4; n++) begin
      key(8'(K_UP + n));
      exp_tx(3, {C_ESC, C_CSI, 8'(ARROW_BASE + n)});
      key(8'(K_PF1 + n));
      exp_tx(3, {C_ESC, C_SS3, 8'(PF_BASE + n)});
    end
    key(C_CR);
    exp_tx(1, C_CR);
    newline_mode_param = 1'b1;
    key(C_CR);
    exp_tx(2, {C_CR, C_LF});
    key(C_DEL);
    exp_tx(1, C_DEL);
    key(C_LF);
    exp_tx(1, C_LF);
    key(C_ESC);
    exp_tx(1, C_ESC);
    key(8'h61, 1'b0, 1'b1);
    exp_tx(1, 8'h01);
    key(K_BREAK);
    chk("break", pl, 8'h80);
    key(K_BREAK, 1'b1);
    chk("long break", pl, 8'h40);
    $display("test normal keys done");
    // Nine bytes against an eight-deep queue with the host stalled
    slow = 1'b0;
    stall = 1'b1;
    key(K_UP);
    key(K_DOWN);
    key(K_PF1);
    cyc(3);
    chk("key ready when full", key_ready, 1'b0);
    stall = 1'b0;
    exp_tx(9, 72'h1B5B411B5B421B4F50);
    chk("drained", tx_valid, 1'b0);
    flow_pause_enable = 1'b1;
    key(K_HOLD);
    chk("hold on", {hold_lamp, host_flow_stop}, 2'h3);
    key(8'h78);
    cyc(10);
    chk("held", i_kfh_host_model.got.size(), 0);
    key(K_HOLD);
    chk("hold off", {hold_lamp, host_flow_stop}, 2'h0);
    exp_tx(1, 8'h78);
    flow_pause_enable = 1'b0;
    key(K_HOLD);
    chk("hold inert", hold_lamp, 1'b0);
    $display("test buffer and hold done");
    key(K_SETUP);
    chk("setup", {setup_active, pl[5]}, 2'h3);
    key(8'h35);
    chk("digit", param_val, 4'h5);
    key(K_SETUP);
    key(8'h87, 1'b1);
    chk("soft reset", pl, 8'h10);
    key(K_SETUP);
    chk("kept", param_val, 4'h5);
    key(8'h30);
    key(K_DOWN);
    chk("down wrap", param_val, 4'h7);
    key(K_UP);
    chk("up wrap", param_val, 4'h0);
    key(C_SP);
    chk("space", param_val, 4'h1);
    key(K_LEFT);
    chk("left wrap", param_idx, 3'h7);
    key(K_RIGHT);
    chk("right wrap", param_idx, 3'h0);
    key(C_CR);
    chk("return", param_idx, 3'h1);
    key(8'h50);
    key(8'h45);
    chk("code", param_idx, 3'h2);
    key(8'h5A);
    key(8'h5A);
    chk("bad code", {param_idx, pl[5]}, 4'h5);
    key(8'h32);
    chk("value", param_val, 4'h2);
    key(8'h33);
    chk("bad value", {param_val, pl[5]}, 5'h05);
    chk("silent", i_kfh_host_model.got.size(), 0);
    key(8'h87);
    chk("restart bell", pl, 8'h20);
    key(8'h87, 1'b1);
    chk("power reset", pl, 8'h08);
    chk("cleared", {param_idx, param_val}, 7'h00);
    $display("test configuration done");
    rst();
    key(8'h85, 1'b1);
    chk("pointer", pointer_active, 1'b1);
    key(K_RIGHT);
    key(K_RIGHT, 1'b1);
    key(K_DOWN);
    key(K_UP, 1'b1);
    chk("moves", {loc_x, loc_y}, {10'h00B, 10'h3F7});
    key(K_ENTER);
    exp_tx(4, 32'h202B3F37);
    chk("exit", pointer_active, 1'b0);
    rst();
    key(8'h85, 1'b1);
    key(8'h61);
    exp_tx(5, 40'h6120202020);
    rst();
    key(8'h85, 1'b1);
    key(C_DEL);
    exp_tx(0, 72'h0);
    rst();
    pulse_in(loc_host_start);
    key(C_DEL);
    exp_tx(1, C_CR);
    rst();
    pulse_in(loc_host_start);
    key(8'h62);
    exp_tx(2, 16'h0D62);
    $display("test locator done");
    key(8'h86, 1'b1);
    chk("text again", {text_mode, pl[0]}, 2'h3);
    pulse_in(gfx_mode_req);
    chk("graphics", graphics_mode, 1'b1);
    key(8'h86, 1'b1);
    chk("to text", {text_mode, graphics_mode, pl[1]}, 3'h5);
    key(K_PF1, 1'b1);
    chk("freeze", {screen_freeze, pl[8]}, 2'h3);
    cyc(FRZ + 5);
    chk("thaw", screen_freeze, 1'b0);
    printer_present = 1'b1;
    key(K_PF1, 1'b1);
    cyc(FRZ + 5);
    chk("copying", screen_freeze, 1'b1);
    pulse_in(printer_done);
    chk("copied", screen_freeze, 1'b0);
    key(K_PF1, 1'b1);
    key(K_PF1, 1'b1);
    chk("abort", pl[2], 1'b1);
    cyc(1);
    chk("aborted", screen_freeze, 1'b0);
    $display("test text and print done");
    close_out();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
